// ===== hw/quad_spi_boot_master.sv
// Quad serial boot master: frame sequencer, shifters and link pins.
// Operation
// R1 - Always the master: drives clock and select, never answers as a slave.
// R2 - Transfers use one, two or four data lines, chosen per frame.
// R3 - Word length programmable from one to 128 bits.
// R4 - Words per frame programmable from one to 4096.
// R5 - Three-, four- or six-pin link forms; six pins for quad lines.
// R6 - Optional event per finished word or per finished frame.
// R7 - Delay of zero to three serial clocks from select to first data.
// R8 - Clock polarity and phase zero; serial clock idles low.
// R9 - Input lines sampled on falling serial clock edges.
// R10 - Duty half for zero or odd divider, else (div/2)/(div+1) high.
// R11 - Software should pick a zero or odd divider for symmetric duty.
// R12 - Select asserted delay field plus one periods before first falling edge.
// R13 - Select released two periods after the final falling edge.
// R14 - Output data changes together with falling serial clock edges.
// R15 - First output bit stands one period before the first falling edge.
// R16 - Output drive starts and ends about one period from select edges; here drive starts on entry to shifting and ends with select release.
// R17 - Frame ends after programmed words; select returns high before next frame.
`timescale 1ns/100ps
`default_nettype none
module quad_spi_boot_master #(
    parameter int DIV_W = qspi_boot_pkg::DIV_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic write_mode,
    input wire logic three_pin_mode,
    input wire logic [1:0] lane_select,
    input wire logic [qspi_boot_pkg::LEN_W-1:0] word_length_field,
    input wire logic [qspi_boot_pkg::CNT_W-1:0] word_count_field,
    input wire logic [qspi_boot_pkg::DD_W-1:0] select_to_data_delay_field,
    input wire logic [DIV_W-1:0] serial_clock_divide_value,
    input wire logic word_event_enable,
    input wire logic frame_event_enable,
    input wire logic [qspi_boot_pkg::SR_W-1:0] tx_word,
    input wire logic [3:0] d_in,
    output logic [3:0] d_out,
    output logic [3:0] d_oe,
    output logic sclk,
    output logic cs_n,
    output logic busy,
    output logic [qspi_boot_pkg::SR_W-1:0] rx_word,
    output logic word_done,
    output logic frame_done,
    output logic word_event,
    output logic frame_event
);
    localparam int SR_W = qspi_boot_pkg::SR_W;
    localparam int BITS_W = qspi_boot_pkg::BITS_W;

    qspi_boot_pkg::state_t state_reg, state_next;
    logic write_reg, write_next;
    logic three_reg, three_next;
    logic [1:0] lanes_reg, lanes_next;
    logic [qspi_boot_pkg::LEN_W-1:0] len_reg, len_next;
    logic [qspi_boot_pkg::CNT_W-1:0] words_left_reg, words_left_next;
    logic [qspi_boot_pkg::DD_W-1:0] dd_reg, dd_next;
    logic [qspi_boot_pkg::DD_W-1:0] lead_reg, lead_next;
    logic [1:0] tail_reg, tail_next;
    logic [DIV_W-1:0] div_reg, div_next;
    logic word_en_reg, word_en_next;
    logic frame_en_reg, frame_en_next;
    logic [BITS_W-1:0] beats_reg, beats_next;
    logic [SR_W-1:0] tx_sr_reg, tx_sr_next;
    logic [SR_W-1:0] rx_sr_reg, rx_sr_next;
    logic [SR_W-1:0] rx_word_reg, rx_word_next;
    logic [3:0] d_out_reg, d_out_next;
    logic [3:0] d_oe_reg, d_oe_next;
    logic cs_n_reg, cs_n_next;
    logic busy_reg, busy_next;
    logic word_done_reg, word_done_next;
    logic frame_done_reg, frame_done_next;
    logic word_event_reg, word_event_next;
    logic frame_event_reg, frame_event_next;
    logic fall_strobe;
    logic sclk_int;
    logic run;
    logic gate;

    // The divider only runs inside a frame, so the clock is low whenever select is high.
    assign run = (state_reg != qspi_boot_pkg::st_idle); // [R1]
    assign gate = (state_reg == qspi_boot_pkg::st_shift);

    sclk_divider #(.DIV_W(DIV_W)) u_div (
        .mclk(mclk),
        .rst(rst),
        .run(run),
        .gate(gate),
        .div(div_reg),
        .sclk(sclk_int),
        .fall_strobe(fall_strobe)
    );

    // Frame sequencer. Configuration is frozen at start so mid-frame port changes
    // cannot corrupt a transfer; tx_word is resampled at every word boundary.
    always_comb begin
        state_next = state_reg;
        write_next = write_reg;
        three_next = three_reg;
        lanes_next = lanes_reg;
        len_next = len_reg;
        words_left_next = words_left_reg;
        dd_next = dd_reg;
        lead_next = lead_reg;
        tail_next = tail_reg;
        div_next = div_reg;
        word_en_next = word_en_reg;
        frame_en_next = frame_en_reg;
        beats_next = beats_reg;
        tx_sr_next = tx_sr_reg;
        rx_sr_next = rx_sr_reg;
        rx_word_next = rx_word_reg;
        d_oe_next = d_oe_reg;
        cs_n_next = cs_n_reg;
        busy_next = busy_reg;
        word_done_next = 1'b0;
        frame_done_next = 1'b0;
        case (state_reg)
            qspi_boot_pkg::st_idle: begin
                if (start) begin
                    write_next = write_mode;
                    three_next = three_pin_mode;
                    lanes_next = three_pin_mode ? qspi_boot_pkg::LANES_SINGLE : lane_select; // [R5]
                    len_next = word_length_field; // [R3]
                    words_left_next = word_count_field; // [R4]
                    dd_next = select_to_data_delay_field;
                    div_next = serial_clock_divide_value;
                    word_en_next = word_event_enable;
                    frame_en_next = frame_event_enable;
                    cs_n_next = 1'b0; // [R1]
                    busy_next = 1'b1;
                    rx_sr_next = '0;
                    lead_next = select_to_data_delay_field;
                    beats_next = qspi_boot_pkg::word_clocks(word_length_field, lanes_next);
                    tx_sr_next = tx_word << (qspi_boot_pkg::SR_BITS -
                                             qspi_boot_pkg::word_bits(word_length_field));
                    if (select_to_data_delay_field == '0) begin
                        // First bit and drive start one period ahead of the first fall.
                        state_next = qspi_boot_pkg::st_shift; // [R15]
                        d_oe_next = write_mode ? qspi_boot_pkg::lane_oe(lanes_next) :
                                    qspi_boot_pkg::OE_NONE; // [R16]
                    end else begin
                        state_next = qspi_boot_pkg::st_lead; // [R7]
                    end
                end
            end
            qspi_boot_pkg::st_lead: begin
                // Idle periods with the clock held low, one per delay count.
                if (fall_strobe) begin
                    if (lead_reg == qspi_boot_pkg::DD_W'(1)) begin
                        state_next = qspi_boot_pkg::st_shift; // [R12]
                        d_oe_next = write_reg ? qspi_boot_pkg::lane_oe(lanes_reg) :
                                    qspi_boot_pkg::OE_NONE; // [R16]
                    end
                    lead_next = lead_reg - qspi_boot_pkg::DD_W'(1);
                end
            end
            qspi_boot_pkg::st_shift: begin
                if (fall_strobe) begin
                    rx_sr_next = qspi_boot_pkg::lane_sample(rx_sr_reg, d_in, lanes_reg,
                                                            three_reg); // [R9] [R2]
                    tx_sr_next = tx_sr_reg << qspi_boot_pkg::lane_count(lanes_reg); // [R14]
                    beats_next = beats_reg - BITS_W'(1);
                    if (beats_reg == BITS_W'(1)) begin
                        rx_word_next = rx_sr_next;
                        word_done_next = 1'b1; // [R6]
                        rx_sr_next = '0;
                        if (words_left_reg == '0) begin
                            state_next = qspi_boot_pkg::st_tail; // [R17]
                            tail_next = qspi_boot_pkg::TAIL_PERIODS;
                        end else begin
                            words_left_next = words_left_reg - qspi_boot_pkg::CNT_W'(1);
                            beats_next = qspi_boot_pkg::word_clocks(len_reg, lanes_reg);
                            tx_sr_next = tx_word << (qspi_boot_pkg::SR_BITS -
                                                     qspi_boot_pkg::word_bits(len_reg));
                        end
                    end
                end
            end
            qspi_boot_pkg::st_tail: begin
                // Clock stays low; select holds for the trailing periods.
                if (fall_strobe) begin
                    tail_next = tail_reg - 2'h1;
                    if (tail_reg == 2'h1) begin
                        state_next = qspi_boot_pkg::st_idle; // [R13]
                        cs_n_next = 1'b1; // [R17]
                        d_oe_next = qspi_boot_pkg::OE_NONE; // [R16]
                        busy_next = 1'b0;
                        frame_done_next = 1'b1; // [R6]
                    end
                end
            end
            default: begin
                state_next = qspi_boot_pkg::st_idle;
                cs_n_next = 1'b1;
                d_oe_next = qspi_boot_pkg::OE_NONE;
                busy_next = 1'b0;
            end
        endcase
        d_out_next = qspi_boot_pkg::lane_out(tx_sr_next, lanes_next); // [R14]
        word_event_next = word_done_next && word_en_reg; // [R6]
        frame_event_next = frame_done_next && frame_en_reg; // [R6]
    end

    // Sequencer and pin registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= qspi_boot_pkg::st_idle;
            write_reg <= 1'b0;
            three_reg <= 1'b0;
            lanes_reg <= qspi_boot_pkg::LANES_SINGLE;
            len_reg <= '0;
            words_left_reg <= '0;
            dd_reg <= '0;
            lead_reg <= '0;
            tail_reg <= '0;
            div_reg <= '0;
            word_en_reg <= 1'b0;
            frame_en_reg <= 1'b0;
            beats_reg <= '0;
            tx_sr_reg <= '0;
            rx_sr_reg <= '0;
            rx_word_reg <= '0;
            d_out_reg <= 4'h0;
            d_oe_reg <= qspi_boot_pkg::OE_NONE;
            cs_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            word_done_reg <= 1'b0;
            frame_done_reg <= 1'b0;
            word_event_reg <= 1'b0;
            frame_event_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            write_reg <= write_next;
            three_reg <= three_next;
            lanes_reg <= lanes_next;
            len_reg <= len_next;
            words_left_reg <= words_left_next;
            dd_reg <= dd_next;
            lead_reg <= lead_next;
            tail_reg <= tail_next;
            div_reg <= div_next;
            word_en_reg <= word_en_next;
            frame_en_reg <= frame_en_next;
            beats_reg <= beats_next;
            tx_sr_reg <= tx_sr_next;
            rx_sr_reg <= rx_sr_next;
            rx_word_reg <= rx_word_next;
            d_out_reg <= d_out_next;
            d_oe_reg <= d_oe_next;
            cs_n_reg <= cs_n_next;
            busy_reg <= busy_next;
            word_done_reg <= word_done_next;
            frame_done_reg <= frame_done_next;
            word_event_reg <= word_event_next;
            frame_event_reg <= frame_event_next;
        end
    end

    assign d_out = d_out_reg;
    assign d_oe = d_oe_reg;
    assign sclk = sclk_int;
    assign cs_n = cs_n_reg;
    assign busy = busy_reg;
    assign rx_word = rx_word_reg;
    assign word_done = word_done_reg;
    assign frame_done = frame_done_reg;
    assign word_event = word_event_reg;
    assign frame_event = frame_event_reg;

    // Timing helpers read only by the checks below.
    int per_i;
    int since_fall;
    int since_cs;
    int high_cnt;
    int words_seen;
    int words_want;
    logic first_seen;
    assign per_i = (div_reg < DIV_W'(2)) ? 2 : int'(div_reg) + 1;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            since_fall <= 0;
            since_cs <= 0;
            high_cnt <= 0;
            words_seen <= 0;
            words_want <= 0;
            first_seen <= 1'b0;
        end else begin
            // The programmed count is held here because the sequencer counts it down.
            words_want <= (state_reg == qspi_boot_pkg::st_idle && start) ?
                          int'(word_count_field) + 1 : words_want;
            since_fall <= $fell(sclk_int) ? 1 : since_fall + 1;
            since_cs <= $fell(cs_n_reg) ? 1 : since_cs + 1;
            high_cnt <= sclk_int ? high_cnt + 1 : 0;
            words_seen <= cs_n_reg ? 0 : words_seen + (word_done_reg ? 1 : 0);
            first_seen <= cs_n_reg ? 1'b0 : (first_seen || $fell(sclk_int));
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_frame_start;
        state_reg == qspi_boot_pkg::st_idle && start;
    endsequence
    sequence s_select_low;
        !cs_n_reg && busy_reg;
    endsequence

    chk_master_start: assert property (s_frame_start |=> s_select_low) // [R1]
        else $error("Select did not assert on frame start.");
    chk_sclk_idle: assert property (cs_n_reg |-> !sclk_int) // [R8]
        else $error("Serial clock not low while deselected.");
    chk_lead_time: assert property ($fell(sclk_int) && !first_seen |->
                                    since_cs == (int'(dd_reg) + 1) * per_i) // [R12]
        else $error("Select to first falling edge time wrong.");
    chk_tail_time: assert property ($rose(cs_n_reg) |-> since_fall == 2 * per_i) // [R13]
        else $error("Last falling edge to select release time wrong.");
    chk_duty_high: assert property ($fell(sclk_int) |-> high_cnt == per_i / 2) // [R10]
        else $error("Serial clock high time wrong.");
    chk_data_fall: assert property (state_reg == qspi_boot_pkg::st_shift &&
                                    $past(state_reg) == qspi_boot_pkg::st_shift &&
                                    $changed(d_out_reg) |-> $fell(sclk_int)) // [R14]
        else $error("Output data changed away from a falling edge.");
    chk_frame_words: assert property (frame_done_reg |->
                                      words_seen == words_want && cs_n_reg) // [R4]
        else $error("Frame ended with wrong word count.");
    chk_word_event: assert property (word_event_reg |-> word_done_reg && word_en_reg) // [R6]
        else $error("Word event without enabled word completion.");
    chk_read_no_drive: assert property (!write_reg || cs_n_reg |-> d_oe_reg == 4'h0) // [R16]
        else $error("Data lines driven outside a write frame.");
    chk_first_bit: assert property ($rose(gate) ##0 write_reg |->
                                    ##1 ($stable(d_out_reg) && d_oe_reg != 4'h0)) // [R15]
        else $error("First output bit not held ahead of first fall.");
endmodule // quad_spi_boot_master
`default_nettype wire

// ===== hw/qspi_boot_pkg.sv
// Shared constants, state codes and lane helpers for the quad serial boot master.
package qspi_boot_pkg;

    // Field widths of the per-frame configuration.
    localparam int SR_W = 128;
    localparam int LEN_W = 7;
    localparam int CNT_W = 12;
    localparam int DD_W = 2;
    localparam int DIV_W = 8;
    localparam int BITS_W = 8;

    // Shifter width in bits, used to left-justify a word.
    localparam logic [BITS_W-1:0] SR_BITS = 8'h80;

    // Lane selection codes.
    localparam logic [1:0] LANES_SINGLE = 2'h0;
    localparam logic [1:0] LANES_DUAL = 2'h1;
    localparam logic [1:0] LANES_QUAD = 2'h2;

    // Output enable patterns for each lane selection.
    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'h1;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hf;

    // Serial clock periods between the last falling edge and select release.
    localparam logic [1:0] TAIL_PERIODS = 2'h2;

    // Frame sequencer states, one-hot.
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_lead = 4'h2,
        st_shift = 4'h4,
        st_tail = 4'h8
    } state_t;

    // Number of data lines used by a lane code.
    function automatic logic [2:0] lane_count(input logic [1:0] lanes);
        if (lanes == LANES_QUAD) begin
            return 3'h4;
        end else if (lanes == LANES_DUAL) begin
            return 3'h2;
        end
        return 3'h1;
    endfunction

    // Word length in bits from its length field, which holds length minus one.
    function automatic logic [BITS_W-1:0] word_bits(input logic [LEN_W-1:0] len);
        return {1'b0, len} + 8'h01;
    endfunction

    // Serial clocks needed for one word; a partial last beat is padded.
    function automatic logic [BITS_W-1:0] word_clocks(input logic [LEN_W-1:0] len,
                                                      input logic [1:0] lanes);
        logic [BITS_W-1:0] bits;
        bits = word_bits(len);
        if (lanes == LANES_QUAD) begin
            return (bits + 8'h03) >> 2;
        end else if (lanes == LANES_DUAL) begin
            return (bits + 8'h01) >> 1;
        end
        return bits;
    endfunction

    // Output enable pattern for a lane code.
    function automatic logic [3:0] lane_oe(input logic [1:0] lanes);
        if (lanes == LANES_QUAD) begin
            return OE_QUAD;
        end else if (lanes == LANES_DUAL) begin
            return OE_DUAL;
        end
        return OE_SINGLE;
    endfunction

    // Data line values taken from the top of the transmit shifter.
    function automatic logic [3:0] lane_out(input logic [SR_W-1:0] sr, input logic [1:0] lanes);
        if (lanes == LANES_QUAD) begin
            return sr[SR_W-1 -: 4];
        end else if (lanes == LANES_DUAL) begin
            return {2'h0, sr[SR_W-1 -: 2]};
        end
        return {3'h0, sr[SR_W-1]};
    endfunction

    // Shift received lines into the bottom of the receive shifter.
    function automatic logic [SR_W-1:0] lane_sample(input logic [SR_W-1:0] sr,
                                                    input logic [3:0] din,
                                                    input logic [1:0] lanes,
                                                    input logic three_pin);
        if (lanes == LANES_QUAD) begin
            return {sr[SR_W-5:0], din};
        end else if (lanes == LANES_DUAL) begin
            return {sr[SR_W-3:0], din[1:0]};
        end else if (three_pin) begin
            return {sr[SR_W-2:0], din[0]};
        end
        return {sr[SR_W-2:0], din[1]};
    endfunction

endpackage

// ===== hw/sclk_divider.sv
// Serial clock generator with a period of divider plus one system clocks, or two for a divider of zero.
`timescale 1ns/100ps
`default_nettype none
module sclk_divider #(
    parameter int DIV_W = qspi_boot_pkg::DIV_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic gate,
    input wire logic [DIV_W-1:0] div,
    output logic sclk,
    output logic fall_strobe
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic sclk_reg;
    logic sclk_next;
    logic [DIV_W-1:0] period_m1;
    logic [DIV_W:0] high_len;
    logic [DIV_W-1:0] low_m1;
    logic rise_strobe;

    // A divider of zero cannot be made from one system clock, so it runs as one.
    // High time is half the period rounded down, so even dividers skew the duty.
    always_comb begin
        period_m1 = (div < DIV_W'(2)) ? DIV_W'(1) : div;
        high_len = ({1'b0, period_m1} + (DIV_W+1)'(1)) >> 1; // [R10]
        low_m1 = period_m1 - high_len[DIV_W-1:0];
        rise_strobe = run && (cnt_reg == low_m1);
        fall_strobe = run && (cnt_reg == period_m1);
        cnt_next = (!run || fall_strobe) ? '0 : cnt_reg + DIV_W'(1);
        sclk_next = sclk_reg;
        if (!run || fall_strobe) begin
            sclk_next = 1'b0; // [R8]
        end else if (rise_strobe && gate) begin
            sclk_next = 1'b1;
        end
    end

    // Counter and clock level registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            sclk_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sclk_reg <= sclk_next;
        end
    end

    assign sclk = sclk_reg;
endmodule // sclk_divider
`default_nettype wire

// ===== hw/unused_placeholder_never.sv
// Intentionally empty marker module file is not needed.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== tb/qspi_flash_model.sv
// Behavioural serial flash that answers every frame with a counting nibble pattern.
`timescale 1ns/100ps
`default_nettype none
module qspi_flash_model (
    input wire logic mclk,
    input wire logic sclk,
    input wire logic cs_n,
    output logic [3:0] d_in
);
    int k = 0;
    initial d_in = 4'h0;
    // Nibble that stands after the n-th falling edge of a frame.
    function automatic logic [3:0] pat(input int n);
        return n[3:0] ^ 4'ha;
    endfunction
    // The first nibble waits a moment so the idle toggling lands before it.
    always @(negedge cs_n) begin
        k = 0;
        #1 d_in = pat(0);
    end
    // Launch just after each falling edge, so the master sees the old nibble at the edge.
    always @(negedge sclk) begin
        k = k + 1;
        #2 d_in = pat(k);
    end
    // Deselected lines float, so they show a changing value instead of the last nibble.
    always @(posedge mclk) begin
        if (cs_n) d_in <= ~d_in;
    end
endmodule // qspi_flash_model
`default_nettype wire

// ===== tb/quad_spi_boot_master_bench.sv
// Self-checking bench for the quad serial boot master.
`timescale 1ns/100ps
`default_nettype none
module quad_spi_boot_master_bench;
    typedef struct {logic tp, wr; logic [1:0] ln; logic [6:0] len; logic [11:0] cnt;
        logic [1:0] dd; logic [7:0] dv; int c;} row_t;
    // Pins, direction, lanes, length-1, words-1, delay, divider, clocks per word.
    // Dividers are mostly zero or odd; one even value checks the skewed duty.
    row_t rows[7] = '{'{0, 1, 2'h0, 7'h00, 12'h000, 2'h0, 8'h01, 1},
        '{0, 0, 2'h1, 7'h07, 12'h000, 2'h1, 8'h03, 4},
        '{0, 1, 2'h2, 7'h7f, 12'h000, 2'h3, 8'h02, 32},
        '{1, 0, 2'h2, 7'h04, 12'h002, 2'h2, 8'h00, 5},
        '{0, 1, 2'h2, 7'h02, 12'h001, 2'h0, 8'h05, 1},
        '{0, 0, 2'h3, 7'h0f, 12'h000, 2'h1, 8'h01, 16},
        '{0, 0, 2'h0, 7'h00, 12'hfff, 2'h0, 8'h00, 1}};
    logic mclk = 1'b0, rst = 1'b1, start = 1'b0, wr = 1'b0, tp = 1'b0, we = 1'b0, fe = 1'b0;
    logic [1:0] ln = 2'h0, dd = 2'h0;
    logic [6:0] len = 7'h00;
    logic [11:0] cnt = 12'h000;
    logic [7:0] dv = 8'h01;
    logic [127:0] tx = 128'h0123456789abcdeffedcba9876543210, rx, cap = 128'h0;
    logic [3:0] d_in, d_out, d_oe, oe;
    logic sclk, cs_n, busy, w_done, f_done, w_ev, f_ev, sq = 1'b0, cq = 1'b1;
    int errors = 0, compares = 0, t = 0, t_sel, t_f1, t_fl, t_rel, hi = 0, hi_l;
    int rises, wd, fd, wv, fv, lw = 1;
    always #4 mclk = ~mclk;
    quad_spi_boot_master dut_u (.mclk(mclk), .rst(rst), .start(start), .write_mode(wr),
        .three_pin_mode(tp), .lane_select(ln), .word_length_field(len),
        .word_count_field(cnt), .select_to_data_delay_field(dd),
        .serial_clock_divide_value(dv), .word_event_enable(we), .frame_event_enable(fe),
        .tx_word(tx), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .sclk(sclk), .cs_n(cs_n),
        .busy(busy), .rx_word(rx), .word_done(w_done), .frame_done(f_done),
        .word_event(w_ev), .frame_event(f_ev));
    qspi_flash_model model_u (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .d_in(d_in));
    // Edge timing on the system clock grid; every distance is taken between like samples.
    always @(posedge mclk) begin
        t <= t + 1;
        sq <= sclk;
        cq <= cs_n;
        hi <= sclk ? hi + 1 : 0;
        wd <= wd + w_done;
        fd <= fd + f_done;
        wv <= wv + w_ev;
        fv <= fv + f_ev;
        if (cq && !cs_n) t_sel <= t;
        if (!sq && sclk) rises <= rises + 1;
        if (sq && !sclk && t_f1 < 0) t_f1 <= t;
        if (sq && !sclk) hi_l <= hi;
        if (sq && !sclk) t_fl <= t;
        if (!cq && cs_n) t_rel <= t;
        if (t > 40000) begin
            errors++;
            stop_test();
        end
    end
    // Output lanes are taken on rising serial clock edges, away from the falling edge where they change.
    always @(posedge sclk) begin
        cap = (cap << lw) | (d_out & ((4'h1 << lw) - 4'h1));
        oe = d_oe;
    end
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        compares++;
        if (e !== g) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One frame from a row; a second start while busy must be ignored.
    task automatic run_frame(input int i);
        int p, nw, k;
        logic [127:0] ex;
        logic [3:0] q;
        p = (rows[i].dv == 8'h00 ? 1 : rows[i].dv) + 1;
        nw = rows[i].cnt + 1;
        lw = rows[i].tp ? 1 : rows[i].ln == 2'h2 ? 4 : rows[i].ln == 2'h1 ? 2 : 1;
        k = lw * rows[i].c;
        @(negedge mclk);
        tp = rows[i].tp;
        wr = rows[i].wr;
        ln = rows[i].ln;
        len = rows[i].len;
        cnt = rows[i].cnt;
        dd = rows[i].dd;
        dv = rows[i].dv;
        we = i[0];
        fe = ~i[0];
        {wd, fd, wv, fv, rises, t_f1} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, -32'sh1};
        start = 1'b1;
        @(negedge mclk) start = 1'b0;
        repeat (2) @(negedge mclk);
        start = 1'b1;
        @(negedge mclk) start = 1'b0;
        while (fd == 0) @(negedge mclk);
        repeat (4) @(negedge mclk);
        chk("lead", (rows[i].dd + 1) * p, t_f1 - t_sel);
        chk("tail", 2 * p, t_rel - t_fl);
        chk("high", p / 2, hi_l);
        chk("clocks", nw * rows[i].c, rises);
        chk("words", nw, wd);
        chk("frames", 1, fd);
        chk("word_event", we ? nw : 0, wv);
        chk("frame_event", fe, fv);
        chk("idle", 7'h20, {busy, cs_n, sclk, d_oe});
        chk("oe", wr ? (4'h1 << lw) - 4'h1 : 4'h0, oe);
        ex = tx << (128 - rows[i].len - 1);
        if (wr) chk("tx", ex >> (128 - k), (cap << (128 - k)) >> (128 - k));
        ex = 128'h0;
        for (int j = (nw - 1) * rows[i].c; j < nw * rows[i].c; j++) begin
            q = model_u.pat(j);
            ex = (ex << lw) | (lw == 4 ? q : lw == 2 ? q & 4'h3 : q[!tp]);
        end
        if (!wr) chk("rx", ex, (rx << (128 - k)) >> (128 - k));
    endtask
    // Reset, the table of frames, then a reset in mid-frame and a recovery frame.
    initial begin
        repeat (8) @(negedge mclk);
        chk("reset", 7'h20, {busy, cs_n, sclk, d_oe});
        rst = 1'b0;
        foreach (rows[i]) run_frame(i);
        start = 1'b1;
        @(negedge mclk) start = 1'b0;
        repeat (20) @(negedge mclk);
        rst = 1'b1;
        @(negedge mclk);
        chk("abort", 7'h20, {busy, cs_n, sclk, d_oe});
        rst = 1'b0;
        run_frame(4);
        stop_test();
    end
endmodule // quad_spi_boot_master_bench
`default_nettype wire
